//--- design/clt_pkg.sv
// Constants and carrier types for the core-local timer and watchdog block
package clt_pkg;

    localparam int ADDR_W = 20;
    localparam int DATA_W = 32;
    localparam int STRB_W = 4;
    localparam int CNT_W = 10;
    localparam int IDX_W = 12;

    // Register windows, byte offsets from the cluster register base
    localparam logic [19:0] SOFT_BASE = 20'h50000;
    localparam logic [19:0] SOFT_LAST = 20'h53FFF;
    localparam logic [19:0] CMP_BASE = 20'h54000;
    localparam logic [19:0] CMP_LAST = 20'h5BFFF;
    localparam logic [19:0] CFG_BASE = 20'h5C000;
    localparam logic [19:0] CFG_LAST = 20'h5CFFF;
    localparam logic [19:0] CSR_BASE = 20'h5D000;
    localparam logic [19:0] CSR_LAST = 20'h5DFFF;
    localparam logic [19:0] SSIP_BASE = 20'h6C000;
    localparam logic [19:0] SSIP_LAST = 20'h6FFFF;

    // watchdog_config fields
    localparam int CFG_RATE_LSB = 8;
    localparam int CFG_S2_LSB = 4;
    localparam int CFG_S1_LSB = 0;
    // watchdog_control_status fields
    localparam int CSR_RELOAD_LSB = 4;
    localparam int CSR_S2_BIT = 3;
    localparam int CSR_S1_BIT = 2;
    localparam int CSR_EN_BIT = 0;
    localparam int SOFT_BIT = 0;

    // Countdown tap is mtime bit TAP_STEP * (rate + 1)
    localparam int TAP_STEP = 8;
    localparam int TAP_NUM = 4;

    localparam logic [63:0] CMP_RESET = 64'hFFFF_FFFF_FFFF_FFFF;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        CLT_ACT_IRQ,
        CLT_ACT_NMI,
        CLT_ACT_RST,
        CLT_ACT_SOC,
        CLT_ACT_PERIODIC
    } clt_action_t;

    typedef enum logic [2:0] {
        CLT_RG_NONE,
        CLT_RG_SOFT,
        CLT_RG_CMP,
        CLT_RG_CFG,
        CLT_RG_CSR,
        CLT_RG_SSIP
    } clt_region_t;

    typedef struct packed {
        clt_region_t region;
        logic [IDX_W-1:0] idx;
        logic hi;
    } clt_dec_t;

    // Per-hart register and watchdog state
    typedef struct packed {
        logic sw_pend;
        logic [63:0] cmp;
        logic [1:0] rate;
        logic [3:0] s2_act;
        logic [3:0] s1_act;
        logic [CNT_W-1:0] reload;
        logic s2_flag;
        logic s1_flag;
        logic en;
        logic [CNT_W-1:0] cnt;
        logic period_irq;
        logic ssip_set;
    } clt_hart_t;

    // Interrupt lines toward one hart
    typedef struct packed {
        logic msi;
        logic mti;
        logic ssi_set;
        logic wdt_irq;
        logic wdt_nmi;
        logic wdt_rst;
    } clt_irq_t;

endpackage : clt_pkg

//--- design/clt_core.sv
// Core-local software interrupts, timer compare and watchdogs per hart
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ns

module clt_core #(
    parameter int N_HARTS = 4
) (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic [63:0] mtime_i,
    input wire logic [clt_pkg::ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [clt_pkg::ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    output logic s_axi_rready_unused_o,
    input wire logic s_axi_rready_i,
    output clt_pkg::clt_irq_t [N_HARTS-1:0] hart_irq_o,
    output logic soc_event_o
);

    typedef struct packed {
        clt_pkg::clt_hart_t [N_HARTS-1:0] hart;
        logic [clt_pkg::TAP_NUM-1:0] tap_prev;
        logic aw_got;
        logic w_got;
        logic [clt_pkg::ADDR_W-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } clt_state_t;

    function automatic clt_state_t reset_state_f();
        clt_state_t s;
        s = '0;
        for (int h = 0; h < N_HARTS; h++) begin
            s.hart[h].cmp = clt_pkg::CMP_RESET;
        end
        return s;
    endfunction : reset_state_f

    localparam clt_state_t RST_STATE = reset_state_f();

    function automatic clt_pkg::clt_dec_t decode_f(
        input logic [clt_pkg::ADDR_W-1:0] a
    );
        clt_pkg::clt_dec_t d;
        logic [clt_pkg::ADDR_W-1:0] off;
        d = '0;
        off = '0;
        d.region = clt_pkg::CLT_RG_NONE;
        if (a >= clt_pkg::SOFT_BASE && a <= clt_pkg::SOFT_LAST) begin
            off = a - clt_pkg::SOFT_BASE;
            d.region = clt_pkg::CLT_RG_SOFT;
            d.idx = off[13:2];
        end else if (a >= clt_pkg::CMP_BASE && a <= clt_pkg::CMP_LAST) begin
            off = a - clt_pkg::CMP_BASE;
            d.region = clt_pkg::CLT_RG_CMP;
            d.idx = off[14:3];
            d.hi = off[2];
        end else if (a >= clt_pkg::CFG_BASE && a <= clt_pkg::CFG_LAST) begin
            off = a - clt_pkg::CFG_BASE;
            d.region = clt_pkg::CLT_RG_CFG;
            d.idx = {2'h0, off[11:2]};
        end else if (a >= clt_pkg::CSR_BASE && a <= clt_pkg::CSR_LAST) begin
            off = a - clt_pkg::CSR_BASE;
            d.region = clt_pkg::CLT_RG_CSR;
            d.idx = {2'h0, off[11:2]};
        end else if (a >= clt_pkg::SSIP_BASE && a <= clt_pkg::SSIP_LAST) begin
            off = a - clt_pkg::SSIP_BASE;
            d.region = clt_pkg::CLT_RG_SSIP;
            d.idx = off[13:2];
        end
        return d;
    endfunction : decode_f

    function automatic logic [31:0] merge_f(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0] strb
    );
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < clt_pkg::STRB_W; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return r;
    endfunction : merge_f

    typedef logic [clt_pkg::IDX_W-1:0] clt_idx_t;

    function automatic logic [31:0] cfg_word_f(
        input clt_pkg::clt_hart_t s
    );
        logic [31:0] w;
        w = '0;
        w[clt_pkg::CFG_RATE_LSB +: 2] = s.rate;
        w[clt_pkg::CFG_S2_LSB +: 4] = s.s2_act;
        w[clt_pkg::CFG_S1_LSB +: 4] = s.s1_act;
        return w;
    endfunction : cfg_word_f

    function automatic logic [31:0] csr_word_f(
        input clt_pkg::clt_hart_t s
    );
        logic [31:0] w;
        w = '0;
        w[clt_pkg::CSR_RELOAD_LSB +: clt_pkg::CNT_W] = s.reload;
        w[clt_pkg::CSR_S2_BIT] = s.s2_flag;
        w[clt_pkg::CSR_S1_BIT] = s.s1_flag;
        w[clt_pkg::CSR_EN_BIT] = s.en;
        return w;
    endfunction : csr_word_f

    clt_state_t st_r;
    clt_state_t st_nxt;
    logic [clt_pkg::TAP_NUM-1:0] tap_now;
    logic aw_hs;
    logic w_hs;
    logic ar_hs;
    logic wr_go;
    clt_pkg::clt_dec_t wr_dec;
    clt_pkg::clt_dec_t rd_dec;
    logic [N_HARTS-1:0] soc_hit;

    // One time counter feeds every hart's compare and countdown
    genvar gt;
    generate
        for (gt = 0; gt < clt_pkg::TAP_NUM; gt++) begin : g_tap
            assign tap_now[gt] = mtime_i[clt_pkg::TAP_STEP*(gt+1)];
        end
    endgenerate

    assign s_axi_awready_o = !st_r.aw_got && !st_r.bvalid;
    assign s_axi_wready_o = !st_r.w_got && !st_r.bvalid;
    assign s_axi_arready_o = !st_r.rvalid;
    assign s_axi_bvalid_o = st_r.bvalid;
    assign s_axi_bresp_o = st_r.bresp;
    assign s_axi_rvalid_o = st_r.rvalid;
    assign s_axi_rdata_o = st_r.rdata;
    assign s_axi_rresp_o = st_r.rresp;
    assign s_axi_rready_unused_o = 1'b0;
    assign aw_hs = s_axi_awvalid_i && s_axi_awready_o;
    assign w_hs = s_axi_wvalid_i && s_axi_wready_o;
    assign ar_hs = s_axi_arvalid_i && s_axi_arready_o;
    // Write is applied one cycle after both halves are held
    assign wr_go = st_r.aw_got && st_r.w_got && !st_r.bvalid;
    assign wr_dec = decode_f(st_r.awaddr);
    assign rd_dec = decode_f(s_axi_araddr_i);

    always_comb begin
        logic tick;
        logic set1;
        logic set2;
        logic hit_w;
        logic hit_r;
        logic [31:0] wv;
        logic [31:0] rv;
        clt_pkg::clt_hart_t hs;
        tick = 1'b0;
        set1 = 1'b0;
        set2 = 1'b0;
        hit_w = 1'b0;
        hit_r = 1'b0;
        wv = '0;
        rv = '0;
        hs = '0;
        st_nxt = st_r;
        st_nxt.tap_prev = tap_now;
        if (aw_hs) begin
            st_nxt.aw_got = 1'b1;
            st_nxt.awaddr = s_axi_awaddr_i;
        end
        if (w_hs) begin
            st_nxt.w_got = 1'b1;
            st_nxt.wdata = s_axi_wdata_i;
            st_nxt.wstrb = s_axi_wstrb_i;
        end
        if (wr_go) begin
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = (wr_dec.region == clt_pkg::CLT_RG_NONE) ?
                clt_pkg::RESP_SLVERR : clt_pkg::RESP_OKAY;
        end
        if (st_r.bvalid && s_axi_bready_i) begin
            st_nxt.bvalid = 1'b0;
        end
        if (st_r.rvalid && s_axi_rready_i) begin
            st_nxt.rvalid = 1'b0;
        end
        for (int h = 0; h < N_HARTS; h++) begin
            hs = st_r.hart[h];
            hs.ssip_set = 1'b0;
            hs.period_irq = 1'b0;
            set1 = 1'b0;
            set2 = 1'b0;
            tick = hs.en && tap_now[hs.rate] && !st_r.tap_prev[hs.rate];
            if (tick) begin
                if (hs.cnt == '0) begin
                    hs.cnt = hs.reload;
                    if (hs.s1_act == clt_pkg::CLT_ACT_PERIODIC) begin
                        hs.period_irq = 1'b1;
                    end else if (!hs.s1_flag) begin
                        set1 = 1'b1;
                    end else begin
                        set2 = 1'b1;
                    end
                end else begin
                    hs.cnt = hs.cnt - 1'b1;
                end
            end
            // Absent harts never match, so their entries read zero
            hit_w = wr_go && (wr_dec.idx == clt_idx_t'(h));
            if (hit_w) begin
                unique case (wr_dec.region)
                    clt_pkg::CLT_RG_SOFT: begin
                        wv = merge_f({31'h0, hs.sw_pend}, st_r.wdata,
                            st_r.wstrb);
                        hs.sw_pend = wv[clt_pkg::SOFT_BIT];
                    end
                    clt_pkg::CLT_RG_CMP: begin
                        if (wr_dec.hi) begin
                            hs.cmp[63:32] = merge_f(hs.cmp[63:32],
                                st_r.wdata, st_r.wstrb);
                        end else begin
                            hs.cmp[31:0] = merge_f(hs.cmp[31:0],
                                st_r.wdata, st_r.wstrb);
                        end
                    end
                    clt_pkg::CLT_RG_CFG: begin
                        wv = merge_f(cfg_word_f(hs), st_r.wdata,
                            st_r.wstrb);
                        hs.rate = wv[clt_pkg::CFG_RATE_LSB +: 2];
                        hs.s2_act = wv[clt_pkg::CFG_S2_LSB +: 4];
                        hs.s1_act = wv[clt_pkg::CFG_S1_LSB +: 4];
                    end
                    clt_pkg::CLT_RG_CSR: begin
                        wv = merge_f(csr_word_f(hs), st_r.wdata,
                            st_r.wstrb);
                        hs.reload = wv[clt_pkg::CSR_RELOAD_LSB +:
                            clt_pkg::CNT_W];
                        hs.s2_flag = wv[clt_pkg::CSR_S2_BIT];
                        hs.s1_flag = wv[clt_pkg::CSR_S1_BIT];
                        hs.en = wv[clt_pkg::CSR_EN_BIT];
                        hs.cnt = hs.reload;
                    end
                    clt_pkg::CLT_RG_SSIP: begin
                        // Only a written one in lane 0 fires
                        hs.ssip_set = st_r.wstrb[0] &&
                            st_r.wdata[clt_pkg::SOFT_BIT];
                    end
                    default: begin
                    end
                endcase
            end
            // Hardware set wins over a software clear in the same cycle
            hs.s1_flag = hs.s1_flag || set1;
            hs.s2_flag = hs.s2_flag || set2;
            st_nxt.hart[h] = hs;
            hit_r = ar_hs && (rd_dec.idx == clt_idx_t'(h));
            if (hit_r) begin
                unique case (rd_dec.region)
                    clt_pkg::CLT_RG_SOFT: rv = {31'h0, st_r.hart[h].sw_pend};
                    clt_pkg::CLT_RG_CMP: rv = rd_dec.hi ?
                        st_r.hart[h].cmp[63:32] : st_r.hart[h].cmp[31:0];
                    clt_pkg::CLT_RG_CFG: rv = cfg_word_f(st_r.hart[h]);
                    clt_pkg::CLT_RG_CSR: rv = csr_word_f(st_r.hart[h]);
                    default: rv = rv; // Supervisor set reads zero
                endcase
            end
        end
        if (ar_hs) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata = rv;
            st_nxt.rresp = (rd_dec.region == clt_pkg::CLT_RG_NONE) ?
                clt_pkg::RESP_SLVERR : clt_pkg::RESP_OKAY;
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_r <= RST_STATE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Action lines are levels from the held flags gated by en, plus the one-cycle periodic pulse on wdt_irq,
    // so a timeout stays visible until software clears the flag or en.
    genvar gh;
    generate
        for (gh = 0; gh < N_HARTS; gh++) begin : g_out
            clt_pkg::clt_hart_t hr;
            logic s1_on;
            logic s2_on;
            assign hr = st_r.hart[gh];
            assign s1_on = hr.s1_flag && hr.en;
            assign s2_on = hr.s2_flag && hr.en;
            assign hart_irq_o[gh].msi = hr.sw_pend;
            assign hart_irq_o[gh].mti = (mtime_i >= hr.cmp);
            assign hart_irq_o[gh].ssi_set = hr.ssip_set;
            assign hart_irq_o[gh].wdt_irq = hr.period_irq ||
                (s1_on && hr.s1_act == clt_pkg::CLT_ACT_IRQ) ||
                (s2_on && hr.s2_act == clt_pkg::CLT_ACT_IRQ);
            assign hart_irq_o[gh].wdt_nmi =
                (s1_on && hr.s1_act == clt_pkg::CLT_ACT_NMI) ||
                (s2_on && hr.s2_act == clt_pkg::CLT_ACT_NMI);
            assign hart_irq_o[gh].wdt_rst =
                (s1_on && hr.s1_act == clt_pkg::CLT_ACT_RST) ||
                (s2_on && hr.s2_act == clt_pkg::CLT_ACT_RST);
            assign soc_hit[gh] =
                (s1_on && hr.s1_act == clt_pkg::CLT_ACT_SOC) ||
                (s2_on && hr.s2_act == clt_pkg::CLT_ACT_SOC);
        end
    endgenerate

    assign soc_event_o = |soc_hit;

endmodule : clt_core

//--- sim/clt_core_sva.sv
// Bus handshake and interrupt-line checks for the core-local timer block
`timescale 1ns/1ns
module clt_chk #(
    parameter int N_HARTS = 4
) (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_wready_o,
    input wire logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic [1:0] s_axi_rresp_o,
    input wire logic s_axi_rvalid_o,
    input wire clt_pkg::clt_irq_t [N_HARTS-1:0] hart_irq_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);
    sequence s_wr;
        s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
    endsequence
    sequence s_b_late;
        !s_axi_bvalid_o ##1 s_axi_bvalid_o;
    endsequence
    property p_b_lat;
        s_wr |=> s_b_late;
    endproperty
    a_b_lat: assert property (p_b_lat) else $error("bvalid timing");
    property p_r_lat;
        s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o;
    endproperty
    a_r_lat: assert property (p_r_lat) else $error("rvalid timing");
    property p_b_hold;
        s_axi_bvalid_o && !s_axi_bready_i |=>
            s_axi_bvalid_o && $stable(s_axi_bresp_o);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
    property p_ar_ref;
        s_axi_rvalid_o |-> !s_axi_arready_o;
    endproperty
    a_ar_ref: assert property (p_ar_ref) else $error("arready with rvalid");
    property p_err_data;
        s_axi_rvalid_o && s_axi_rresp_o == 2'h2 |-> s_axi_rdata_o == 32'h0;
    endproperty
    a_err_data: assert property (p_err_data) else $error("error data");
    property p_msi;
        $changed(hart_irq_o[N_HARTS-1].msi) |-> $rose(s_axi_bvalid_o);
    endproperty
    a_msi: assert property (p_msi) else $error("msi moved alone");
    property p_ssi;
        hart_irq_o[N_HARTS-1].ssi_set |=> !hart_irq_o[N_HARTS-1].ssi_set;
    endproperty
    a_ssi: assert property (p_ssi) else $error("ssi pulse long");
    property p_wdt_fall;
        $fell(hart_irq_o[0].wdt_nmi) || $fell(hart_irq_o[0].wdt_rst) |->
            $rose(s_axi_bvalid_o);
    endproperty
    a_wdt_fall: assert property (p_wdt_fall) else $error("wdt drop");
endmodule : clt_chk

bind clt_core clt_chk #(.N_HARTS(N_HARTS)) i_chk (.sys_clk_i, .arst_n_i,
    .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o,
    .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i,
    .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
    .hart_irq_o);

//--- sim/clt_hart_model.sv
// Far side: shared time counter, harts latching their ssi_set pulses, and a count of hart 0 wdt_irq pulses
`timescale 1ns/1ns
module clt_hart_model #(
    parameter int N_HARTS = 4
) (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic ld_i,
    input wire logic [63:0] ld_val_i,
    input wire clt_pkg::clt_irq_t [N_HARTS-1:0] irq_i,
    output logic [63:0] mtime_o,
    output logic [N_HARTS-1:0] pend_o,
    output logic [7:0] pulse_cnt_o
);
    logic irq_r;
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mtime_o <= 64'h0;
            pend_o <= '0;
            irq_r <= 1'h0;
            pulse_cnt_o <= 8'h0;
        end else begin
            // Jumps let slow watchdog taps be reached quickly
            mtime_o <= ld_i ? ld_val_i : mtime_o + 64'h1;
            // The hart holds pending; the block only sends a set pulse
            for (int h = 0; h < N_HARTS; h++) begin
                if (irq_i[h].ssi_set) pend_o[h] <= 1'h1;
            end
            irq_r <= irq_i[0].wdt_irq;
            if (irq_i[0].wdt_irq && !irq_r) begin
                pulse_cnt_o <= pulse_cnt_o + 8'h1;
            end
        end
    end
endmodule : clt_hart_model

//--- sim/clt_core_tb.sv
// Register-level tests for the core-local timer and watchdog block
`timescale 1ns/1ns
module clt_core_tb;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic [19:0] awaddr = 20'h0;
    logic [19:0] araddr = 20'h0;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0, ld = 1'h0;
    logic [63:0] ld_val = 64'h0;
    logic awready, wready, bvalid, arready, rvalid, soc;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [63:0] mtime;
    logic [3:0] pend;
    logic [7:0] pcnt;
    clt_pkg::clt_irq_t [3:0] irq;
    int fails = 0;
    int checks = 0;
    always #25 clk = ~clk;
    clt_core #(.N_HARTS(4)) i_dut (.sys_clk_i(clk), .arst_n_i(rst_n),
        .mtime_i(mtime), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_unused_o(), .s_axi_rready_i(rready),
        .hart_irq_o(irq), .soc_event_o(soc));
    clt_hart_model #(.N_HARTS(4)) i_hart (.sys_clk_i(clk), .arst_n_i(rst_n),
        .ld_i(ld), .ld_val_i(ld_val), .irq_i(irq), .mtime_o(mtime),
        .pend_o(pend), .pulse_cnt_o(pcnt));
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic c1(input string nm, input logic e, input logic g);
        chk(nm, {31'h0, e}, {31'h0, g});
    endtask : c1
    task automatic wr(input logic [19:0] a, input logic [31:0] d,
                      input logic [1:0] er = 2'h0);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        forever begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
            if (bvalid && bready) break;
        end
        bready <= 1'h0;
        chk("bresp", {30'h0, er}, {30'h0, bresp});
    endtask : wr
    task automatic rd(input logic [19:0] a, input logic [31:0] e,
                      input logic [31:0] m = 32'hFFFF_FFFF,
                      input logic [1:0] er = 2'h0);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        forever begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'h0;
            if (rvalid && rready) break;
        end
        rready <= 1'h0;
        chk("rdata", e, rdata & m);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
    endtask : rd
    task automatic setm(input logic [63:0] v);
        @(posedge clk);
        ld <= 1'h1;
        ld_val <= v;
        @(posedge clk);
        ld <= 1'h0;
    endtask : setm
    // Time lands 20 counts below the tap, so one rising edge follows
    task automatic tick();
        setm(64'hEC);
        repeat (30) @(posedge clk);
    endtask : tick
    task automatic stop_test();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test
    initial begin
        #(50 * 20000);
        fails++;
        $display("[ERR] run expected end seen timeout");
        stop_test();
    end
    initial begin
        logic [31:0] v;
        clt_pkg::clt_irq_t e;
        repeat (12) @(posedge clk);
        rst_n <= 1'h1;
        rd(20'h50000, 32'h0);
        rd(20'h54004, 32'hFFFF_FFFF);
        rd(20'h5C000, 32'h0);
        rd(20'h5D000, 32'h0, 32'h1);
        c1("mti0", 1'h0, irq[0].mti);
        wr(20'h5000C, 32'hFFFF_FFFF);
        c1("msi3", 1'h1, irq[3].msi);
        c1("msi0", 1'h0, irq[0].msi);
        rd(20'h5000C, 32'h1);
        wr(20'h5000C, 32'h0);
        c1("msi3", 1'h0, irq[3].msi);
        wr(20'h50010, 32'h1);
        rd(20'h50010, 32'h0);
        wr(20'h40000, 32'h1, 2'h2);
        rd(20'h40000, 32'h0, 32'hFFFF_FFFF, 2'h2);
        setm(64'h0);
        wr(20'h54010, 32'h80);
        wr(20'h54014, 32'h0);
        rd(20'h54008, 32'hFFFF_FFFF);
        c1("mti2", 1'h0, irq[2].mti);
        repeat (120) @(posedge clk);
        c1("mti2", 1'h1, irq[2].mti);
        c1("mti1", 1'h0, irq[1].mti);
        wr(20'h6C00C, 32'h1);
        wr(20'h6C008, 32'h0);
        chk("pend", 32'h8, {28'h0, pend});
        rd(20'h6C00C, 32'h0);
        wr(20'h5C004, 32'hFFFF_FFFF);
        rd(20'h5C004, 32'h3FF);
        wr(20'h5D010, 32'h1);
        rd(20'h5D010, 32'h0);
        wr(20'h5C000, 32'hFF);
        wr(20'h5D000, 32'h21);
        tick();
        tick();
        rd(20'h5D000, 32'h21);
        tick();
        rd(20'h5D000, 32'h25);
        wr(20'h5D000, 32'h0);
        tick();
        rd(20'h5D000, 32'h0);
        for (int r = 0; r < 4; r++) begin
            wr(20'h5C000, {22'h0, r[1:0], 8'hFF});
            wr(20'h5D000, 32'h1);
            setm((64'h1 << (8 * (r + 1))) - 64'h14);
            rd(20'h5D000, 32'h1);
            repeat (30) @(posedge clk);
            rd(20'h5D000, 32'h5);
        end
        for (int s = 1; s < 3; s++) begin
            for (int c = 0; c < 4; c++) begin
                v = (s == 1) ? 32'hF0 | c : 32'hF | (c << 4);
                wr(20'h5C000, v);
                wr(20'h5D000, 32'h1);
                tick();
                if (s == 2) tick();
                rd(20'h5D000, (s == 1) ? 32'h5 : 32'hD);
                e = '0;
                e.wdt_irq = (c == 0);
                e.wdt_nmi = (c == 1);
                e.wdt_rst = (c == 2);
                chk("irq0", {26'h0, e}, {26'h0, irq[0]});
                c1("soc", c == 3, soc);
                repeat (20) @(posedge clk);
                chk("irq0", {26'h0, e}, {26'h0, irq[0]});
            end
        end
        wr(20'h5C000, 32'h4);
        wr(20'h5D000, 32'h1);
        v = {24'h0, pcnt};
        tick();
        tick();
        chk("pulses", v + 32'h2, {24'h0, pcnt});
        rd(20'h5D000, 32'h1);
        c1("wdt_irq", 1'h0, irq[0].wdt_irq);
        stop_test();
    end
endmodule : clt_core_tb
